// file: rtl/acs_pkg.sv
// shared types and constants for the adc conversion sequencer
package acs_pkg;

  // register select codes carried in the communications register
  localparam logic [2:0] REG_COMM = 3'h0;
  localparam logic [2:0] REG_SETUP = 3'h1;
  localparam logic [2:0] REG_CLOCK = 3'h2;
  localparam logic [2:0] REG_DATA = 3'h3;
  localparam logic [2:0] REG_OFFSET = 3'h6;
  localparam logic [2:0] REG_GAIN = 3'h7;

  // reset values
  localparam logic [7:0] COMM_RESET = 8'h00;
  localparam logic [7:0] SETUP_RESET = 8'h01;
  localparam logic [7:0] CLOCK_RESET = 8'h85;
  localparam logic [15:0] DATA_RESET = 16'h0000;
  localparam logic [23:0] OFFSET_RESET = 24'h000000;
  localparam logic [23:0] GAIN_RESET = 24'h800000;

  // timing, in input-clock cycles or output-rate periods
  localparam int unsigned MOD_CYCLES = 128;
  localparam logic [10:0] PIPE_CYCLES = 11'h7d0;
  localparam logic [8:0] REPULSE_CYCLES = 9'h1f4;
  localparam logic [3:0] NORM_RDY_PERIODS = 4'h3;
  localparam logic [3:0] SELF_CAL_PERIODS = 4'h6;
  localparam logic [3:0] SELF_RDY_PERIODS = 4'h9;
  localparam logic [3:0] SYS_CAL_PERIODS = 4'h3;
  localparam logic [3:0] SYS_RDY_PERIODS = 4'h4;

  // decimation ratio indexed by {range select, filter rate bits}
  localparam logic [8:0] DEC_RATE [0:7] = '{
    9'h187, 9'h139, 9'h04e, 9'h027, 9'h180, 9'h140, 9'h04d, 9'h026
  };

  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_SELF = 2'h1,
    MODE_ZERO = 2'h2,
    MODE_FULL = 2'h3
  } acs_mode_t;

  typedef struct packed {
    logic data_ready_n;
    logic [2:0] reg_sel;
    logic read;
    logic power_down_bit;
    logic [1:0] channel;
  } acs_comm_t;

  typedef struct packed {
    acs_mode_t mode;
    logic [2:0] gain;
    logic unipolar;
    logic buffered;
    logic filter_sync;
  } acs_setup_t;

  typedef struct packed {
    logic identification_bit;
    logic [1:0] zero;
    logic clock_output_disable;
    logic input_clock_halver;
    logic range_select;
    logic filter_rate_bit_high;
    logic filter_rate_bit_low;
  } acs_clock_t;

  // one completed register transfer from the serial front end
  typedef struct packed {
    logic strobe;
    logic [23:0] wdata;
  } acs_xfer_t;

  typedef enum logic [3:0] {
    ST_HOLD = 4'b0001,
    ST_CAL = 4'b0010,
    ST_PIPE = 4'b0100,
    ST_RUN = 4'b1000
  } acs_state_t;

endpackage

// file: rtl/acs_sequencer.sv
// conversion sequencer: register file, rate timing, calibration, data ready
`timescale 1ns/1ps
`default_nettype none

module acs_sequencer (
  // clock and power-on reset
  input wire logic clock,
  input wire logic rst_n,
  // reset pin, asynchronous to clock
  input wire logic reset_pin_n,
  // register transfers from the serial front end
  input wire acs_pkg::acs_xfer_t xfer,
  output logic [23:0] rd_data,
  // filter path
  input wire logic [15:0] conv_data,
  input wire logic [23:0] cal_coeff,
  output logic filter_hold,
  // pins
  output logic data_ready_n,
  output logic clock_output_pin
);

  // reset pin synchroniser
  logic rs1_q, rs2_q, rs3_q, pin_rst_q, pin_rst_d;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rs1_q <= 1'b1;
      rs2_q <= 1'b1;
      rs3_q <= 1'b1;
    end else begin
      rs1_q <= reset_pin_n;
      rs2_q <= rs1_q;
      rs3_q <= rs2_q;
    end
  end

  always_comb begin
    pin_rst_d = pin_rst_q;
    if (rs2_q == rs3_q) begin
      pin_rst_d = !rs3_q;
    end
  end

  // clock output: the power-on reset or clock_output_disable stops it, never the pin
  logic clk_out_q, clk_out_d;
  acs_pkg::acs_clock_t clk_q, clk_d;

  always_comb begin
    clk_out_d = clk_q.clock_output_disable ? 1'b0 : !clk_out_q;
  end

  // register file and sequencer state
  acs_pkg::acs_comm_t comm_q, comm_d;
  acs_pkg::acs_setup_t setup_q, setup_d;
  logic [15:0] data_q, data_d;
  logic [23:0] offs_q [0:1];
  logic [23:0] offs_d [0:1];
  logic [23:0] gain_q [0:1];
  logic [23:0] gain_d [0:1];
  logic pend_q, pend_d;
  logic hold_prev_q, hold_prev_d;
  acs_pkg::acs_state_t st_q, st_d;
  logic [16:0] per_cnt_q, per_cnt_d;
  logic [3:0] per_num_q, per_num_d;
  logic [3:0] tgt_q, tgt_d;
  logic [3:0] cal_len_q, cal_len_d;
  logic is_cal_q, is_cal_d;
  logic cal_ch_q, cal_ch_d;
  logic [1:0] cal_mode_q, cal_mode_d;
  logic [10:0] pipe_cnt_q, pipe_cnt_d;
  logic [8:0] pulse_cnt_q, pulse_cnt_d;
  logic data_ready_n_q, data_ready_n_d;
  logic hold_out_q, hold_out_d;
  logic [23:0] rd_q, rd_d;

  logic [8:0] dec;
  logic [16:0] per_len;
  logic per_tick, hold, cal_wr, start, result, read_done;
  acs_pkg::acs_setup_t wsetup;
  logic [3:0] per_next;

  always_comb begin
    dec = acs_pkg::DEC_RATE[{clk_q.range_select, clk_q.filter_rate_bit_high,
                             clk_q.filter_rate_bit_low}];
    per_len = 17'(dec) * 17'(acs_pkg::MOD_CYCLES);
    if (clk_q.input_clock_halver) begin
      per_len = {per_len[15:0], 1'b0};
    end
  end

  // period counter on the input clock, held at zero in ST_HOLD and cleared at a start
  assign per_tick = per_cnt_q >= per_len - 17'h00001;
  assign hold = setup_q.filter_sync | comm_q.power_down_bit;
  assign wsetup = acs_pkg::acs_setup_t'(xfer.wdata[7:0]);
  assign per_next = per_num_q + 4'h1;

  always_comb begin
    comm_d = comm_q;
    setup_d = setup_q;
    clk_d = clk_q;
    data_d = data_q;
    offs_d = offs_q;
    gain_d = gain_q;
    pend_d = pend_q;
    st_d = st_q;
    per_cnt_d = per_tick ? 17'h00000 : per_cnt_q + 17'h00001;
    per_num_d = per_num_q;
    tgt_d = tgt_q;
    cal_len_d = cal_len_q;
    is_cal_d = is_cal_q;
    cal_ch_d = cal_ch_q;
    cal_mode_d = cal_mode_q;
    pipe_cnt_d = pipe_cnt_q;
    pulse_cnt_d = pulse_cnt_q;
    data_ready_n_d = data_ready_n_q;
    hold_prev_d = hold;
    result = 1'b0;
    read_done = 1'b0;
    cal_wr = 1'b0;

    // register transfers
    if (xfer.strobe) begin
      if (!pend_q) begin
        comm_d = acs_pkg::acs_comm_t'(xfer.wdata[7:0]);
        pend_d = 1'b1;
      end else begin
        pend_d = 1'b0;
        if (comm_q.read) begin
          read_done = comm_q.reg_sel == acs_pkg::REG_DATA;
        end else begin
          unique case (comm_q.reg_sel)
            acs_pkg::REG_SETUP: begin
              setup_d = wsetup;
              cal_wr = wsetup.mode != acs_pkg::MODE_NORMAL;
            end
            acs_pkg::REG_CLOCK: begin
              clk_d = acs_pkg::acs_clock_t'(xfer.wdata[7:0]);
              clk_d.identification_bit = 1'b1;
              clk_d.zero = 2'h0;
            end
            acs_pkg::REG_OFFSET: offs_d[comm_q.channel[0]] = xfer.wdata;
            acs_pkg::REG_GAIN: gain_d[comm_q.channel[0]] = xfer.wdata;
            default: begin
              // data and test writes are taken and discarded
            end
          endcase
        end
      end
    end

    // a start is a falling hold or a calibration command under low sync and low power-down bit
    start = (hold_prev_q && !hold) || (cal_wr && !hold);

    if (pulse_cnt_q != 9'h000) begin
      pulse_cnt_d = pulse_cnt_q - 9'h001;
      if (pulse_cnt_q == 9'h001) begin
        data_ready_n_d = 1'b0;
      end
    end

    unique case (st_q)
      acs_pkg::ST_HOLD: begin
        per_cnt_d = 17'h00000;
      end
      acs_pkg::ST_CAL: begin
        if (per_tick) begin
          per_num_d = per_next;
          if (is_cal_q && per_next == cal_len_q) begin
            setup_d.mode = acs_pkg::MODE_NORMAL;
            unique case (cal_mode_q)
              acs_pkg::MODE_ZERO: offs_d[cal_ch_q] = cal_coeff;
              acs_pkg::MODE_FULL: gain_d[cal_ch_q] = cal_coeff;
              default: begin
                offs_d[cal_ch_q] = cal_coeff;
                gain_d[cal_ch_q] = cal_coeff;
              end
            endcase
          end
          if (per_next == tgt_q) begin
            if (is_cal_q) begin
              st_d = acs_pkg::ST_PIPE;
              pipe_cnt_d = acs_pkg::PIPE_CYCLES;
            end else begin
              st_d = acs_pkg::ST_RUN;
              result = 1'b1;
            end
          end
        end
      end
      acs_pkg::ST_PIPE: begin
        pipe_cnt_d = pipe_cnt_q - 11'h001;
        if (pipe_cnt_q == 11'h001) begin
          st_d = acs_pkg::ST_RUN;
          result = 1'b1;
          per_cnt_d = 17'h00000;
        end
      end
      acs_pkg::ST_RUN: begin
        result = per_tick;
      end
    endcase

    if (result) begin
      data_d = conv_data;
      if (!data_ready_n_q && pulse_cnt_q == 9'h000) begin
        data_ready_n_d = 1'b1;
        pulse_cnt_d = acs_pkg::REPULSE_CYCLES;
      end else begin
        data_ready_n_d = 1'b0;
        pulse_cnt_d = 9'h000;
      end
    end

    // a read completes the handshake, unless a new word lands now
    if (read_done && !result) begin
      data_ready_n_d = 1'b1;
      pulse_cnt_d = 9'h000;
    end

    if (hold) begin
      st_d = acs_pkg::ST_HOLD;
    end else if (start) begin
      st_d = acs_pkg::ST_CAL;
      per_cnt_d = 17'h00000;
      per_num_d = 4'h0;
      data_ready_n_d = 1'b1;
      pulse_cnt_d = 9'h000;
      cal_ch_d = comm_d.channel[0];
      cal_mode_d = setup_d.mode;
      is_cal_d = setup_d.mode != acs_pkg::MODE_NORMAL;
      unique case (setup_d.mode)
        acs_pkg::MODE_NORMAL: begin
          tgt_d = acs_pkg::NORM_RDY_PERIODS;
          cal_len_d = acs_pkg::NORM_RDY_PERIODS;
        end
        acs_pkg::MODE_SELF: begin
          tgt_d = acs_pkg::SELF_RDY_PERIODS;
          cal_len_d = acs_pkg::SELF_CAL_PERIODS;
        end
        default: begin
          tgt_d = acs_pkg::SYS_RDY_PERIODS;
          cal_len_d = acs_pkg::SYS_CAL_PERIODS;
        end
      endcase
    end

    // reset pin: defaults back, transfers dropped, data ready high
    if (pin_rst_q) begin
      comm_d = acs_pkg::acs_comm_t'(acs_pkg::COMM_RESET);
      setup_d = acs_pkg::acs_setup_t'(acs_pkg::SETUP_RESET);
      clk_d = acs_pkg::acs_clock_t'(acs_pkg::CLOCK_RESET);
      data_d = acs_pkg::DATA_RESET;
      offs_d = '{acs_pkg::OFFSET_RESET, acs_pkg::OFFSET_RESET};
      gain_d = '{acs_pkg::GAIN_RESET, acs_pkg::GAIN_RESET};
      pend_d = 1'b0;
      st_d = acs_pkg::ST_HOLD;
      pulse_cnt_d = 9'h000;
      data_ready_n_d = 1'b1;
    end

    hold_out_d = hold || st_d == acs_pkg::ST_HOLD;

    // readback path; the data word stays readable mid conversion
    unique case (comm_q.reg_sel)
      acs_pkg::REG_COMM: rd_d = {16'h0000, data_ready_n_q, comm_q[6:0]};
      acs_pkg::REG_SETUP: rd_d = {16'h0000, setup_q};
      acs_pkg::REG_CLOCK: rd_d = {16'h0000, clk_q};
      acs_pkg::REG_DATA: rd_d = {8'h00, data_q};
      acs_pkg::REG_OFFSET: rd_d = offs_q[comm_q.channel[0]];
      acs_pkg::REG_GAIN: rd_d = gain_q[comm_q.channel[0]];
      default: rd_d = 24'h000000;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_rst_q <= 1'b0;
      clk_out_q <= 1'b0;
      comm_q <= acs_pkg::acs_comm_t'(acs_pkg::COMM_RESET);
      setup_q <= acs_pkg::acs_setup_t'(acs_pkg::SETUP_RESET);
      clk_q <= acs_pkg::acs_clock_t'(acs_pkg::CLOCK_RESET);
      data_q <= acs_pkg::DATA_RESET;
      offs_q <= '{acs_pkg::OFFSET_RESET, acs_pkg::OFFSET_RESET};
      gain_q <= '{acs_pkg::GAIN_RESET, acs_pkg::GAIN_RESET};
      pend_q <= 1'b0;
      hold_prev_q <= 1'b1;
      st_q <= acs_pkg::ST_HOLD;
      per_cnt_q <= 17'h00000;
      per_num_q <= 4'h0;
      tgt_q <= 4'h0;
      cal_len_q <= 4'h0;
      is_cal_q <= 1'b0;
      cal_ch_q <= 1'b0;
      cal_mode_q <= 2'h0;
      pipe_cnt_q <= 11'h000;
      pulse_cnt_q <= 9'h000;
      data_ready_n_q <= 1'b1;
      hold_out_q <= 1'b1;
      rd_q <= 24'h000000;
    end else begin
      pin_rst_q <= pin_rst_d;
      clk_out_q <= clk_out_d;
      comm_q <= comm_d;
      setup_q <= setup_d;
      clk_q <= clk_d;
      data_q <= data_d;
      offs_q <= offs_d;
      gain_q <= gain_d;
      pend_q <= pend_d;
      hold_prev_q <= hold_prev_d;
      st_q <= st_d;
      per_cnt_q <= per_cnt_d;
      per_num_q <= per_num_d;
      tgt_q <= tgt_d;
      cal_len_q <= cal_len_d;
      is_cal_q <= is_cal_d;
      cal_ch_q <= cal_ch_d;
      cal_mode_q <= cal_mode_d;
      pipe_cnt_q <= pipe_cnt_d;
      pulse_cnt_q <= pulse_cnt_d;
      data_ready_n_q <= data_ready_n_d;
      hold_out_q <= hold_out_d;
      rd_q <= rd_d;
    end
  end

  assign data_ready_n = data_ready_n_q;
  assign clock_output_pin = clk_out_q;
  assign filter_hold = hold_out_q;
  assign rd_data = rd_q;

endmodule

`default_nettype wire

// file: verif/acs_sequencer_properties.sv
// port checker for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_properties (
  // clock and resets
  input wire logic clock,
  input wire logic rst_n,
  input wire logic reset_pin_n,
  // transfers and pins
  input wire acs_pkg::acs_xfer_t xfer,
  input wire logic filter_hold,
  input wire logic data_ready_n,
  input wire logic clock_output_pin
);
  logic [7:0] pin_q;
  logic [3:0] stb_q;
  logic [11:0] hi_q;
  logic turn_q, drd_q, swr_q, rep_q, pin_ok;

  // the pin reset reaches the outputs a few edges late, so stay clear of it
  assign pin_ok = reset_pin_n && (&pin_q);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pin_q <= 8'h00;
      stb_q <= 4'h0;
      hi_q <= 12'h000;
      turn_q <= 1'b1;
      drd_q <= 1'b0;
      swr_q <= 1'b0;
      rep_q <= 1'b0;
    end else begin
      pin_q <= {pin_q[6:0], reset_pin_n};
      stb_q <= {stb_q[2:0], xfer.strobe};
      hi_q <= data_ready_n ? hi_q + {11'h000, ~&hi_q} : 12'h000;
      if (!pin_ok || filter_hold) begin
        rep_q <= 1'b0;
      end else if (data_ready_n && hi_q == 12'h000) begin
        rep_q <= stb_q == 4'h0 && !xfer.strobe;
      end
      if (!pin_ok) begin
        turn_q <= 1'b1;
      end else if (xfer.strobe) begin
        turn_q <= !turn_q;
        if (turn_q) begin
          drd_q <= xfer.wdata[6:3] == 4'h7;
          swr_q <= xfer.wdata[6:3] == 4'h2;
        end
      end
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_setup_wr;
    pin_ok && xfer.strobe && !turn_q && swr_q;
  endsequence
  sequence s_data_rd;
    pin_ok && xfer.strobe && !turn_q && drd_q;
  endsequence

  a_pin_ready: assert property (!reset_pin_n [*6] |=> data_ready_n)
    else $error("data ready low during pin reset");
  a_clock_output_pin_runs: assert property (!reset_pin_n |=>
    clock_output_pin != $past(clock_output_pin))
    else $error("clock output stopped in pin reset");
  a_hold_quiet: assert property (
    pin_ok && filter_hold && data_ready_n |=> data_ready_n)
    else $error("result while filter held");
  a_sync_keeps_low: assert property (pin_ok && filter_hold &&
    !data_ready_n && stb_q == 4'h0 && !xfer.strobe |=> !data_ready_n)
    else $error("data ready released without read");
  a_repulse_len: assert property (pin_ok && !filter_hold &&
    $fell(data_ready_n) && rep_q |-> hi_q inside {[12'h1f3:12'h1f5]})
    else $error("overwrite pulse length wrong");
  a_read_clears: assert property (s_data_rd |-> ##[1:2] data_ready_n)
    else $error("data read did not raise data ready");
  a_sync_holds: assert property (
    s_setup_wr ##0 xfer.wdata[0] |-> ##[1:2] filter_hold)
    else $error("filter not held after sync write");
  a_cal_ready_high: assert property (s_setup_wr ##0
    (!xfer.wdata[0] && xfer.wdata[7:6] != 2'h0) |-> ##[1:4] data_ready_n)
    else $error("data ready not raised at calibration");
endmodule

bind acs_sequencer acs_sequencer_properties u_props (
  .clock(clock), .rst_n(rst_n), .reset_pin_n(reset_pin_n), .xfer(xfer),
  .filter_hold(filter_hold), .data_ready_n(data_ready_n),
  .clock_output_pin(clock_output_pin));
`default_nettype wire

// file: verif/acs_host_model.sv
// host model issuing register transfers
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
  // clock
  input wire logic clock,
  // transfer port
  output var acs_pkg::acs_xfer_t xfer,
  input wire logic [23:0] rd_data
);
  initial xfer = '{strobe: 1'b0, wdata: 24'h000000};

  // released data is inverted so a stale value never looks valid
  task automatic send(input logic [23:0] w);
    @(posedge clock);
    #1;
    xfer = '{strobe: 1'b1, wdata: w};
    @(posedge clock);
    #1;
    xfer = '{strobe: 1'b0, wdata: ~w};
  endtask

  task automatic wr(input logic [2:0] r, input logic [23:0] d);
    send({17'h00000, r, 4'h0});
    send(d);
  endtask

  task automatic rd(input logic [2:0] r, output logic [23:0] d);
    send({17'h00000, r, 4'h8});
    @(posedge clock);
    #1;
    d = rd_data;
    send(24'h000000);
  endtask
endmodule
`default_nettype wire

// file: verif/tb_adc_conversion_sequencer.sv
// testbench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_adc_conversion_sequencer;
  localparam int P = 128 * 38;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic reset_pin_n = 1'b1;
  logic [15:0] conv_data = 16'h1234;
  logic [23:0] cal_coeff = 24'h000000;
  acs_pkg::acs_xfer_t xfer;
  logic [23:0] rd_data, v;
  logic filter_hold, data_ready_n, clock_output_pin;
  int fails = 0;
  int samples_checked = 0;
  int n, n2;

  always #20 clock = ~clock;

  acs_sequencer dut (.clock(clock), .rst_n(rst_n),
    .reset_pin_n(reset_pin_n), .xfer(xfer), .rd_data(rd_data),
    .conv_data(conv_data), .cal_coeff(cal_coeff),
    .filter_hold(filter_hold), .data_ready_n(data_ready_n),
    .clock_output_pin(clock_output_pin));
  acs_host_model host (.clock(clock), .xfer(xfer), .rd_data(rd_data));

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  // counts may differ by the register stages at either end
  task automatic near(input int got, input int exp);
    samples_checked++;
    if (got < exp - 3 || got > exp + 3) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fails++;
    end
  endtask

  task automatic wait_rdy(input logic lvl, input int lim, output int c);
    c = 0;
    while (data_ready_n !== lvl) begin
      @(posedge clock);
      #1;
      c++;
      if (c > lim) begin
        $display("Error at %0t: got %h expected %h", $time, c, lim);
        fails++;
        summarize();
      end
    end
  endtask

  task automatic t_defaults;
    host.rd(3'h1, v);
    check(v, 24'h000001);
    host.rd(3'h2, v);
    check(v, 24'h000085);
    host.rd(3'h6, v);
    check(v, 24'h000000);
    host.rd(3'h7, v);
    check(v, 24'h800000);
    host.rd(3'h4, v);
    check(v, 24'h000000);
    host.rd(3'h0, v);
    check({23'h0, v[7]}, 24'h000001);
    $display("register defaults done");
  endtask

  task automatic t_normal;
    host.wr(3'h2, 24'h000007);
    host.wr(3'h1, 24'h000000);
    wait_rdy(1'b0, 4 * P, n);
    near(n, 3 * P + 2);
    host.rd(3'h3, v);
    check(v, 24'h001234);
    host.rd(3'h3, v);
    check(v, 24'h001234);
    check({23'h0, data_ready_n}, 24'h000001);
    conv_data = 16'h5a5a;
    wait_rdy(1'b0, P, n);
    wait_rdy(1'b1, P + 10, n2);
    wait_rdy(1'b0, 600, n);
    near(n, 500);
    near(n2, P);
    host.rd(3'h3, v);
    check(v, 24'h005a5a);
    $display("normal conversion done");
  endtask

  task automatic t_sync_stop;
    host.wr(3'h1, 24'h000001);
    repeat (600) @(posedge clock);
    #1;
    check({23'h0, filter_hold}, 24'h000001);
    check({23'h0, data_ready_n}, 24'h000000);
    host.rd(3'h0, v);
    check({23'h0, v[7]}, 24'h000000);
    host.rd(3'h3, v);
    check({23'h0, data_ready_n}, 24'h000001);
    $display("sync stop done");
  endtask

  task automatic t_syscal;
    for (int m = 2; m < 4; m++) begin
      host.rd(3'h3, v);
      host.wr(3'h1, 24'h000001);
      cal_coeff = m == 2 ? 24'h0a0b0c : 24'h7f0102;
      host.wr(3'h1, {16'h0000, m[1:0], 6'h00});
      wait_rdy(1'b0, 5 * P + 2100, n);
      near(n, 4 * P + 2002);
      host.rd(3'h1, v);
      check(v & 24'h0000c0, 24'h000000);
      host.rd(m == 2 ? 3'h6 : 3'h7, v);
      check(v, cal_coeff);
    end
    $display("system calibration done");
  endtask

  // the full nine-period wait would blow the cycle budget, so only the
  // mode-bit clear and the coefficient update are timed here
  task automatic t_self;
    cal_coeff = 24'h3c5a69;
    host.wr(3'h1, 24'h000040);
    repeat (6 * P - 20) @(posedge clock);
    #1;
    host.rd(3'h1, v);
    check(v, 24'h000040);
    repeat (24) @(posedge clock);
    #1;
    host.rd(3'h1, v);
    check(v, 24'h000000);
    host.rd(3'h6, v);
    check(v, cal_coeff);
    host.rd(3'h7, v);
    check(v, cal_coeff);
    check({23'h0, data_ready_n}, 24'h000001);
    $display("self calibration done");
  endtask

  task automatic t_pin;
    @(posedge clock);
    #1;
    reset_pin_n = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    check({23'h0, data_ready_n}, 24'h000001);
    v[0] = clock_output_pin;
    @(posedge clock);
    #1;
    check({23'h0, clock_output_pin}, {23'h0, ~v[0]});
    host.wr(3'h2, 24'h000003);
    reset_pin_n = 1'b1;
    repeat (10) @(posedge clock);
    host.rd(3'h2, v);
    check(v, 24'h000085);
    host.rd(3'h1, v);
    check(v, 24'h000001);
    $display("pin reset done");
  endtask

  initial begin
    repeat (2) @(posedge clock);
    #1;
    rst_n = 1'b1;
    repeat (10) @(posedge clock);
    t_defaults();
    t_normal();
    // system calibration leaves an unread word, which the sync stop needs
    t_syscal();
    t_sync_stop();
    t_self();
    t_pin();
    summarize();
  end
endmodule
`default_nettype wire
